// ### common/cpt_pkg.sv
// constants, field layouts and carriers for the codec parameter table
//------------------------------------------------------------------------
// Notes on behaviour
// - every parameter is fixed read-only; no command can change one
// - id 00h on root: maker id in 31:16, part id in 15:0
// - identity answer goes on the primary input line, whatever address
// - id 02h: rsvd 31:24, major 23:20, minor 19:16, vendor 15:8, step 7:0
// - id 04h: first child node in 23:16, child count in 7:0
// - id 05h: unsolicited flag bit 8, group kind code in 7:0
// - vendor widgets inside the audio group lack id 05h, report type Fh
// - id 08h: tone source bit 16, input delay 11:8, output delay 3:0
// - zero group delay means widgets on that path report their delay
// - id 09h on a widget: type in 23:20, delay in 19:16
// - widget type codes 0h to 7h and Fh; 8h to Eh reserved
// - volume knob may report bits 19:0 zero; host assumes unsol, list
// - tone widget uses only output amp bit 2 and amp override bit 3
// - swap capable two-way widget swaps on both paths; default none
// - link list bit is 1 for input converter, mixer, selector and pin
// - unsol capable pin emits an event on each presence change
// - stripe bit is 0 except on an output converter
// - format override reads 0 on pin complexes
// - amp override 0 means group defaults serve both amplifiers
// - input amp only on mixer, input conv, pin; output amp on output conv, mixer, selector, pin, tone
// - digital bit is 1 for a widget carrying a digital stream
// - stereo bit is 1 for stereo widgets, 0 for mono
//------------------------------------------------------------------------
package cpt_pkg;
    // parameter ids
    localparam logic [7:0] CPT_PID_IDENT  = 8'h00;
    localparam logic [7:0] CPT_PID_REV    = 8'h02;
    localparam logic [7:0] CPT_PID_NODES  = 8'h04;
    localparam logic [7:0] CPT_PID_GKIND  = 8'h05;
    localparam logic [7:0] CPT_PID_AGCAPS = 8'h08;
    localparam logic [7:0] CPT_PID_WCAPS  = 8'h09;
    // node map
    localparam logic [7:0] CPT_ROOT_NODE  = 8'h00;
    localparam logic [7:0] CPT_AFG_NODE   = 8'h01;
    localparam logic [7:0] CPT_AFG_COUNT  = 8'h01;
    localparam logic [7:0] CPT_W_FIRST    = 8'h02;
    localparam int         CPT_NUM_W      = 8;
    localparam logic [7:0] CPT_W_COUNT    = 8'h08;
    // identity, values arbitrary
    localparam logic [15:0] CPT_MAKER_ID  = 16'h1234;
    localparam logic [15:0] CPT_PART_ID   = 16'h5678;
    localparam logic [3:0]  CPT_SPEC_MAJ  = 4'h1;
    localparam logic [3:0]  CPT_SPEC_MIN  = 4'h0;
    localparam logic [7:0]  CPT_VEND_REV  = 8'h01;
    localparam logic [7:0]  CPT_STEP_NUM  = 8'h00;
    // group kind codes
    localparam logic [7:0] CPT_KIND_AUDIO = 8'h01;
    localparam logic [7:0] CPT_KIND_MODEM = 8'h02;
    localparam logic [7:0] CPT_KIND_VEND  = 8'h80;
    localparam logic       CPT_AFG_UNSOL  = 1'b0;
    // audio group caps
    localparam logic       CPT_TONE_PRES  = 1'b1;
    localparam logic [3:0] CPT_IN_DELAY   = 4'h2;
    localparam logic [3:0] CPT_OUT_DELAY  = 4'h0;
    // widget type codes
    localparam logic [3:0] CPT_WT_OUT     = 4'h0;
    localparam logic [3:0] CPT_WT_IN      = 4'h1;
    localparam logic [3:0] CPT_WT_MIX     = 4'h2;
    localparam logic [3:0] CPT_WT_SEL     = 4'h3;
    localparam logic [3:0] CPT_WT_PIN     = 4'h4;
    localparam logic [3:0] CPT_WT_PWR     = 4'h5;
    localparam logic [3:0] CPT_WT_KNOB    = 4'h6;
    localparam logic [3:0] CPT_WT_TONE    = 4'h7;
    localparam logic [3:0] CPT_WT_VEND    = 4'hF;
    // widget sample delays on the zero-delay output path
    localparam logic [3:0] CPT_OUTCONV_DLY = 4'h1;
    localparam logic [3:0] CPT_PIN_DLY     = 4'h1;
    // serial data input lane that carries the identity answer
    localparam logic [1:0] CPT_PRIMARY_SDI = 2'h0;
    localparam int         CPT_PIN_INDEX   = 4;

    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic [3:0] wtype;
        logic [3:0] delay;
        logic [3:0] rsvd_mid;
        logic       swap;
        logic       widget_power_state_support;
        logic       digital;
        logic       input_link_list_present;
        logic       unsol;
        logic       processing_controls_present;
        logic       stripe;
        logic       fmt_override;
        logic       amp_override;
        logic       out_amp;
        logic       in_amp;
        logic       stereo;
    } cpt_wcaps_s;

    typedef struct packed {
        logic       valid;
        logic       is_set;
        logic [1:0] cad;
        logic [7:0] node;
        logic [7:0] param;
    } cpt_req_s;

    typedef struct packed {
        logic        valid;
        logic [1:0]  lane;
        logic [31:0] data;
    } cpt_rsp_s;

    localparam cpt_rsp_s CPT_RSP_IDLE = '0;
endpackage

// ### rtl/cpt_param_table.sv
// capability parameter table of the codec, answering parameter fetches
`timescale 1ns/10ps
module cpt_param_table
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire cpt_pkg::cpt_req_s req,
    input  wire logic          presence_detect,
    input  wire logic          unsol_enable,
    output cpt_pkg::cpt_rsp_s  rsp,
    output logic               unsol_pulse
);
    import cpt_pkg::*;

    //--------------------------------------------------------------------
    // widget capability table
    //--------------------------------------------------------------------

    // fixed build per widget; nothing in the design writes these
    function automatic cpt_wcaps_s cpt_widget_caps(input int idx);
        cpt_wcaps_s c;
        c = '0;
        case (idx)
            0:
            begin
                // output converter, analog, fed only from the link
                c.wtype        = CPT_WT_OUT;
                c.in_amp       = 1'b0; // no input side
                c.amp_override = 1'b0; // group defaults
                c.swap         = 1'b0; // one direction only
                c.delay        = CPT_OUTCONV_DLY;
                c.stripe       = 1'b0; // no stripe command
                c.fmt_override = 1'b1;
                c.out_amp      = 1'b1;
                c.digital      = 1'b0;
                c.widget_power_state_support = 1'b1;
                c.input_link_list_present    = 1'b0;
                c.stereo       = 1'b1;
            end
            1:
            begin
                // digital input converter, mono
                c.wtype        = CPT_WT_IN;
                c.stripe       = 1'b0;
                c.out_amp      = 1'b0;
                c.delay        = 4'h0; // group word holds it
                c.digital      = 1'b1;
                c.in_amp       = 1'b1;
                c.fmt_override = 1'b1;
                c.input_link_list_present = 1'b1;
                c.stereo       = 1'b0;
            end
            2:
            begin
                // mixer, both amplifiers from group defaults
                c.wtype        = CPT_WT_MIX;
                c.fmt_override = 1'b0; // group formats
                c.stripe       = 1'b0;
                c.digital      = 1'b0;
                c.in_amp       = 1'b1;
                c.out_amp      = 1'b1;
                c.amp_override = 1'b0;
                c.input_link_list_present = 1'b1;
                c.stereo       = 1'b1;
            end
            3:
            begin
                // selector has no input amplifier by its nature
                c.wtype        = CPT_WT_SEL;
                c.in_amp       = 1'b0;
                c.stripe       = 1'b0;
                c.digital      = 1'b0;
                c.out_amp      = 1'b1;
                c.amp_override = 1'b1;
                c.input_link_list_present = 1'b1;
                c.processing_controls_present = 1'b1;
                c.stereo       = 1'b1;
            end
            4:
            begin
                // pin complex, two-way, swaps on both paths
                c.wtype        = CPT_WT_PIN;
                c.stripe       = 1'b0;
                c.digital      = 1'b0; // analog jack
                c.delay        = CPT_PIN_DLY;
                c.swap         = 1'b1;
                c.unsol        = 1'b1;
                c.fmt_override = 1'b0;
                c.in_amp       = 1'b1;
                c.out_amp      = 1'b1;
                c.input_link_list_present = 1'b1;
                c.stereo       = 1'b1;
            end
            5:
            begin
                // volume knob keeps bits 19:0 at zero
                c.wtype        = CPT_WT_KNOB;
                c.unsol        = 1'b0; // host assumes it
                c.input_link_list_present = 1'b0;
            end
            6:
            begin
                // tone source: only amp bits carry meaning
                c.wtype        = CPT_WT_TONE;
                c.stereo       = 1'b0; // unused here
                c.in_amp       = 1'b0;
                c.out_amp      = 1'b1;
                c.amp_override = 1'b1;
            end
            default:
            begin
                // vendor widget inside the audio group
                c.wtype        = CPT_WT_VEND;
                c.stripe       = 1'b0;
                c.delay        = 4'h0;
            end
        endcase
        return c;
    endfunction

    //--------------------------------------------------------------------
    // node decode
    //--------------------------------------------------------------------

    wire logic        is_root;
    wire logic        is_afg;
    wire logic        is_widget;
    wire logic        is_vendor_w;
    wire logic [7:0]  w_offset;
    wire logic [31:0] w_caps_sel;
    wire logic [31:0] w_caps_part [CPT_NUM_W];
    logic      [31:0] w_caps_or;
    wire cpt_wcaps_s  sel_caps;

    // node classes; widgets occupy a contiguous block after the group
    assign is_root   = (req.node == CPT_ROOT_NODE);
    assign is_afg    = (req.node == CPT_AFG_NODE);
    // the subtract wraps for low nodes; the lower bound check covers it
    assign w_offset  = req.node - CPT_W_FIRST;
    assign is_widget = (req.node >= CPT_W_FIRST) &&
                       (w_offset < CPT_W_COUNT);

    // one masked copy per widget, merged below
    genvar gi;
    generate
        for (gi = 0; gi < CPT_NUM_W; gi = gi + 1)
        begin : g_widget
            wire logic hit;
            assign hit = is_widget && (w_offset == 8'(gi));
            assign w_caps_part[gi] = hit ? 32'(cpt_widget_caps(gi))
                                         : 32'h0000_0000;
        end
    endgenerate

    // at most one part is nonzero, so an or serves as the mux
    always_comb
    begin
        w_caps_or = 32'h0000_0000;
        for (int i = 0; i < CPT_NUM_W; i = i + 1)
        begin
            w_caps_or = w_caps_or | w_caps_part[i];
        end
    end

    // typed view of the merged word, so no field position is hand coded
    assign w_caps_sel  = w_caps_or;
    assign sel_caps    = cpt_wcaps_s'(w_caps_or);
    assign is_vendor_w = is_widget &&
                         (sel_caps.wtype == CPT_WT_VEND);

    //--------------------------------------------------------------------
    // response words
    //--------------------------------------------------------------------

    wire logic [31:0] ident_word;
    wire logic [31:0] rev_word;
    wire logic [31:0] root_nodes_word;
    wire logic [31:0] afg_nodes_word;
    wire logic [31:0] afg_kind_word;
    wire logic [31:0] afg_caps_word;

    assign ident_word      = {CPT_MAKER_ID, CPT_PART_ID};
    assign rev_word        = {8'h00, CPT_SPEC_MAJ, CPT_SPEC_MIN,
                              CPT_VEND_REV, CPT_STEP_NUM};
    // root lists the function groups, the group lists its widgets
    assign root_nodes_word = {8'h00, CPT_AFG_NODE,
                              8'h00, CPT_AFG_COUNT};
    assign afg_nodes_word  = {8'h00, CPT_W_FIRST,
                              8'h00, CPT_W_COUNT};
    assign afg_kind_word   = {23'h000000, CPT_AFG_UNSOL,
                              CPT_KIND_AUDIO};
    // zero output delay pushes the figure onto the widgets
    assign afg_caps_word   = {15'h0000, CPT_TONE_PRES, 4'h0,
                              CPT_IN_DELAY, 4'h0,
                              CPT_OUT_DELAY};

    //--------------------------------------------------------------------
    // parameter select
    //--------------------------------------------------------------------

    wire logic   is_get;
    wire logic   pick_ident;
    wire logic   pick_rev;
    wire logic   pick_root_nodes;
    wire logic   pick_afg_nodes;
    wire logic   pick_afg_kind;
    wire logic   pick_afg_caps;
    wire logic   pick_wcaps;
    wire logic   pick_vendor_kind;
    logic [31:0] rsp_data_nxt;
    logic [1:0]  rsp_lane_nxt;

    // a set never selects a table word, so nothing can be altered
    assign is_get           = !req.is_set;
    assign pick_ident       = is_get && is_root &&
                              (req.param == CPT_PID_IDENT);
    assign pick_rev         = is_get && is_root &&
                              (req.param == CPT_PID_REV);
    assign pick_root_nodes  = is_get && is_root &&
                              (req.param == CPT_PID_NODES);
    assign pick_afg_nodes   = is_get && is_afg &&
                              (req.param == CPT_PID_NODES);
    assign pick_afg_kind    = is_get && is_afg &&
                              (req.param == CPT_PID_GKIND);
    assign pick_afg_caps    = is_get && is_afg &&
                              (req.param == CPT_PID_AGCAPS);
    assign pick_wcaps       = is_get && is_widget &&
                              (req.param == CPT_PID_WCAPS);
    // vendor widgets carry no kind word
    assign pick_vendor_kind = is_get && is_vendor_w &&
                              (req.param == CPT_PID_GKIND);

    // anything not matched falls to zero
    always_comb
    begin
        rsp_data_nxt = 32'h0000_0000;
        if (req.is_set)
        begin
            // set commands are acknowledged but never stored
            rsp_data_nxt = 32'h0000_0000;
        end
        else if (pick_ident)
        begin
            rsp_data_nxt = ident_word;
        end
        else if (pick_rev)
        begin
            rsp_data_nxt = rev_word;
        end
        else if (pick_root_nodes)
        begin
            rsp_data_nxt = root_nodes_word;
        end
        else if (pick_afg_nodes)
        begin
            rsp_data_nxt = afg_nodes_word;
        end
        else if (pick_afg_kind)
        begin
            rsp_data_nxt = afg_kind_word;
        end
        else if (pick_afg_caps)
        begin
            rsp_data_nxt = afg_caps_word;
        end
        else if (pick_wcaps)
        begin
            rsp_data_nxt = w_caps_sel;
        end
        else if (pick_vendor_kind)
        begin
            // vendor widget has no kind parameter
            rsp_data_nxt = 32'h0000_0000;
        end
        else
        begin
            rsp_data_nxt = 32'h0000_0000;
        end
    end

    // identity always returns on the primary lane
    assign rsp_lane_nxt = pick_ident ? CPT_PRIMARY_SDI : req.cad;

    //--------------------------------------------------------------------
    // response register
    //--------------------------------------------------------------------

    cpt_rsp_s rsp_r;

    // one answer per request, one cycle later
    // lane and data hold between answers; only the strobe drops
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_r <= CPT_RSP_IDLE;
        end
        else
        begin
            rsp_r.valid <= req.valid;
            if (req.valid)
            begin
                rsp_r.lane <= rsp_lane_nxt;
                rsp_r.data <= rsp_data_nxt;
            end
        end
    end

    assign rsp = rsp_r;

    //--------------------------------------------------------------------
    // presence change events
    //--------------------------------------------------------------------

    logic pd_prev_r;
    logic primed_r;
    logic unsol_r;
    wire logic pin_unsol_cap;
    wire logic pd_changed;
    wire cpt_wcaps_s pin_caps;

    // capability bit gates the event, so the table and pin agree
    assign pin_caps      = cpt_widget_caps(CPT_PIN_INDEX);
    assign pin_unsol_cap = pin_caps.unsol;
    // primed skips the first sample, whose history is unknown
    assign pd_changed    = primed_r && (presence_detect != pd_prev_r);

    // one pulse per changed edge; while disabled a change is dropped,
    // not queued, so enabling later never replays an old change
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pd_prev_r <= 1'b0;
            primed_r  <= 1'b0;
            unsol_r   <= 1'b0;
        end
        else
        begin
            pd_prev_r <= presence_detect;
            primed_r  <= 1'b1;
            unsol_r   <= pd_changed && unsol_enable &&
                         pin_unsol_cap;
        end
    end

    assign unsol_pulse = unsol_r;
endmodule

// ### bench/cpt_param_table_monitor.sv
// checker watching the parameter table ports
`timescale 1ns/10ps
module cpt_param_table_monitor
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire cpt_pkg::cpt_req_s req,
    input  wire logic              presence_detect,
    input  wire logic              unsol_enable,
    input  wire cpt_pkg::cpt_rsp_s rsp,
    input  wire logic              unsol_pulse
);
    import cpt_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    //------------------------------------------------------------
    // helper decode
    //------------------------------------------------------------
    // presence history is only valid from the second edge on
    logic live_r;
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b) live_r <= 1'b0;
        else        live_r <= 1'b1;
    wire is_get  = req.valid && !req.is_set;
    wire cpt_wcaps_s seen_caps = rsp.data;
    wire ident_q = is_get && req.node == CPT_ROOT_NODE
                   && req.param == CPT_PID_IDENT;
    wire rev_q   = is_get && req.node == CPT_ROOT_NODE
                   && req.param == CPT_PID_REV;
    wire wcaps_q = is_get && req.node >= CPT_W_FIRST
                   && req.node < CPT_W_FIRST + CPT_W_COUNT
                   && req.param == CPT_PID_WCAPS;
    wire odd_id  = req.valid && !(req.param inside {CPT_PID_IDENT,
                   CPT_PID_REV, CPT_PID_NODES, CPT_PID_GKIND,
                   CPT_PID_AGCAPS, CPT_PID_WCAPS});
    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    sequence pd_event_s;
        live_r && unsol_enable && $changed(presence_detect);
    endsequence
    answer_follows_a: assert property (req.valid |=> rsp.valid)
        else $error("no answer one cycle after a fetch");
    answer_holds_a: assert property (!req.valid
        |=> !rsp.valid && $stable(rsp.data))
        else $error("answer changed without a fetch");
    ident_lane_a: assert property (ident_q
        |=> rsp.lane == CPT_PRIMARY_SDI
        && rsp.data == {CPT_MAKER_ID, CPT_PART_ID})
        else $error("identity answer wrong or on wrong lane");
    other_lane_a: assert property (req.valid && !ident_q
        |=> rsp.lane == $past(req.cad))
        else $error("answer lane differs from request lane");
    rev_layout_a: assert property (rev_q |=> rsp.data == {8'h00,
        CPT_SPEC_MAJ, CPT_SPEC_MIN, CPT_VEND_REV, CPT_STEP_NUM})
        else $error("revision answer wrong");
    set_zero_a: assert property (req.valid && req.is_set
        |=> rsp.data == 32'h0000_0000)
        else $error("set command answered nonzero");
    odd_id_zero_a: assert property (odd_id
        |=> rsp.data == 32'h0000_0000)
        else $error("unknown id answered nonzero");
    caps_rsvd_a: assert property (wcaps_q
        |=> seen_caps.rsvd_hi == 8'h00 && seen_caps.rsvd_mid == 4'h0)
        else $error("widget caps reserved bits set");
    stripe_only_a: assert property (wcaps_q
        |=> !seen_caps.stripe || seen_caps.wtype == CPT_WT_OUT)
        else $error("stripe bit on a non output widget");
    pin_fmt_a: assert property (wcaps_q
        |=> !seen_caps.fmt_override || seen_caps.wtype != CPT_WT_PIN)
        else $error("format override set on pin widget");
    unsol_follow_a: assert property (pd_event_s |=> unsol_pulse)
        else $error("presence change gave no event");
    unsol_quiet_a: assert property (!(live_r && unsol_enable
        && $changed(presence_detect)) |=> !unsol_pulse)
        else $error("event without an enabled presence change");
endmodule
bind cpt_param_table cpt_param_table_monitor u_mon (.clk(clk),
    .rst_b(rst_b), .req(req), .presence_detect(presence_detect),
    .unsol_enable(unsol_enable), .rsp(rsp), .unsol_pulse(unsol_pulse));

// ### bench/cpt_host_model.sv
// host link controller model issuing parameter fetches
`timescale 1ns/10ps
module cpt_host_model
(
    input  wire logic  clk,
    output cpt_pkg::cpt_req_s req,
    output logic       presence_detect,
    output logic       unsol_enable
);
    import cpt_pkg::*;
    // knob caps may read zero; host counts on unsol and list anyway
    localparam logic KNOB_ASSUMED = 1'b1;
    //------------------------------------------------------------
    // drivers
    //------------------------------------------------------------
    initial
    begin
        req = '0;
        presence_detect = 1'b0;
        unsol_enable = 1'b0;
    end
    // valid stays up so successive calls run back to back
    task automatic fetch(input logic [7:0] node, input logic [7:0] pid,
                         input logic [1:0] cad, input logic set);
        req = '{valid: 1'b1, is_set: set, cad: cad, node: node,
                param: pid};
        @(posedge clk);
        #1;
    endtask
    // released node and param fields flip, is_set and cad hold, so a stale value never passes for live
    task automatic idle();
        req = '{valid: 1'b0, is_set: req.is_set, cad: req.cad,
                node: ~req.node, param: ~req.param};
    endtask
    task automatic drive_pd(input logic pd, input logic en);
        presence_detect = pd;
        unsol_enable = en;
        @(posedge clk);
        #1;
    endtask
endmodule

// ### bench/cpt_param_table_tb.sv
// self-checking bench for the codec parameter table
`timescale 1ns/10ps
module cpt_param_table_tb;
    import cpt_pkg::*;
    logic     clk;
    logic     rst_b;
    cpt_req_s req;
    logic     presence_detect;
    logic     unsol_enable;
    cpt_rsp_s rsp;
    logic     unsol_pulse;
    int       fail_count;
    int       n_compared;
    int       cycles;
    logic [1:0] cad_r;
    //------------------------------------------------------------
    // instances and clock
    //------------------------------------------------------------
    cpt_param_table u_cpt_param_table (.clk(clk), .rst_b(rst_b),
        .req(req), .presence_detect(presence_detect),
        .unsol_enable(unsol_enable), .rsp(rsp), .unsol_pulse(unsol_pulse));
    cpt_host_model u_host (.clk(clk), .req(req),
        .presence_detect(presence_detect), .unsol_enable(unsol_enable));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard, far above the 38 or so cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            summarize();
        end
    end
    //------------------------------------------------------------
    // tasks
    //------------------------------------------------------------
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check32(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    task automatic check1(input string name, input logic exp,
                          input logic got);
        n_compared++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %b seen %b", name, exp, got);
            fail_count++;
        end
    endtask
    function automatic logic [31:0] wc(input logic [3:0] t,
        input logic [3:0] d, input logic [11:0] f);
        return {8'h00, t, d, 4'h0, f};
    endfunction
    // one fetch, lane expected primary only for the identity id
    task automatic tf(input logic [7:0] node, input logic [7:0] pid,
                      input logic set, input logic [31:0] exp);
        logic [1:0] lane_exp;
        lane_exp = (node == CPT_ROOT_NODE && pid == CPT_PID_IDENT && !set)
                   ? CPT_PRIMARY_SDI : cad_r;
        u_host.fetch(node, pid, cad_r, set);
        check1("answer strobe", 1'b1, rsp.valid);
        check32("answer lane", {30'h0, lane_exp}, {30'h0, rsp.lane});
        check32("answer word", exp, rsp.data);
        cad_r = cad_r + 2'h1;
    endtask
    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        cad_r = 2'h2;
        fail_count = 0;
        n_compared = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        tf(CPT_ROOT_NODE, CPT_PID_IDENT, 0,
           {CPT_MAKER_ID, CPT_PART_ID});
        tf(CPT_ROOT_NODE, CPT_PID_REV, 0, {8'h00, CPT_SPEC_MAJ,
           CPT_SPEC_MIN, CPT_VEND_REV, CPT_STEP_NUM});
        tf(CPT_ROOT_NODE, CPT_PID_NODES, 0, {8'h00, CPT_AFG_NODE, 8'h00,
           CPT_AFG_COUNT});
        tf(CPT_AFG_NODE, CPT_PID_NODES, 0, {8'h00, CPT_W_FIRST, 8'h00,
           CPT_W_COUNT});
        tf(CPT_AFG_NODE, CPT_PID_GKIND, 0, {23'h0, CPT_AFG_UNSOL,
           CPT_KIND_AUDIO});
        tf(CPT_AFG_NODE, CPT_PID_AGCAPS, 0, {15'h0, CPT_TONE_PRES, 4'h0,
           CPT_IN_DELAY, 4'h0, CPT_OUT_DELAY});
        tf(8'h02, CPT_PID_WCAPS, 0, wc(CPT_WT_OUT, CPT_OUTCONV_DLY,
           12'h415));
        tf(8'h03, CPT_PID_WCAPS, 0,
           wc(CPT_WT_IN, 4'h0, 12'h312));
        tf(8'h04, CPT_PID_WCAPS, 0,
           wc(CPT_WT_MIX, 4'h0, 12'h107));
        tf(8'h05, CPT_PID_WCAPS, 0, wc(CPT_WT_SEL, 4'h0, 12'h14D));
        tf(8'h06, CPT_PID_WCAPS, 0, wc(CPT_WT_PIN, CPT_PIN_DLY,
           12'h987));
        tf(8'h07, CPT_PID_WCAPS, 0, wc(CPT_WT_KNOB, 4'h0, 12'h000));
        tf(8'h08, CPT_PID_WCAPS, 0, wc(CPT_WT_TONE, 4'h0, 12'h00C));
        tf(8'h09, CPT_PID_WCAPS, 0, wc(CPT_WT_VEND, 4'h0, 12'h000));
        tf(8'h09, CPT_PID_GKIND, 0, 32'h0000_0000);
        tf(8'h0A, CPT_PID_WCAPS, 0, 32'h0000_0000);
        tf(CPT_ROOT_NODE, 8'h0A, 0, 32'h0000_0000);
        tf(CPT_ROOT_NODE, CPT_PID_IDENT, 1, 32'h0000_0000);
        tf(CPT_ROOT_NODE, CPT_PID_IDENT, 0,
           {CPT_MAKER_ID, CPT_PART_ID});
        u_host.idle();
        @(posedge clk);
        #1;
        check1("idle strobe", 1'b0, rsp.valid);
        check32("held word", {CPT_MAKER_ID, CPT_PART_ID}, rsp.data);
        $display("test fetch table done");
        // steps: pd 1,1,0,1,0,0 en 1,1,1,1,0,1, events 1,0,1,1,0,0
        for (int i = 0; i < 6; i++)
        begin
            u_host.drive_pd(1'(6'b001011 >> i),
                            1'(6'b101111 >> i));
            check1("presence event", 1'(6'b001101 >> i),
                   unsol_pulse);
        end
        $display("test presence events done");
        summarize();
    end
endmodule
